// [core/adcdp_pkg.sv]
// register map, field layout and shared types of the digital path block
// assumes a 32-bit apb slave; every register sits at byte 4 * index
package adcdp_pkg;
    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_SKEW   = 8'h1e;
    localparam logic [7:0] IDX_FRAME  = 8'h20;
    localparam logic [7:0] IDX_ROUTE  = 8'h24;
    localparam logic [7:0] IDX_DECIM  = 8'h25;
    localparam logic [7:0] IDX_STATUS = 8'h30;
    localparam int         ADDR_LSB   = 2;
    // field positions
    localparam int SKEW_DATA_LSB = 2;
    localparam int SKEW_CLK_LSB  = 0;
    localparam int PAT_W         = 20;
    localparam int FRAME_SCR_BIT = 22;
    localparam int ROUTE_AVG_BIT = 5;
    localparam int ROUTE_SEL_LSB = 3;
    localparam int ROUTE_DIG_BIT = 2;
    localparam int ROUTE_DDC_BIT = 1;
    localparam int DEC_MUX_BIT   = 7;
    localparam int DEC_CODE_LSB  = 4;
    localparam int DEC_REAL_BIT  = 3;
    localparam int DEC_INV_BIT   = 0;
    localparam int STAT_PEND_BIT = 0;
    // reset values and encodings
    localparam logic [23:0] FRAME_RESET = 24'h0ffc00;
    localparam logic [19:0] PAT_BYPASS  = 20'hff000;
    localparam logic [2:0]  DEC_BYPASS  = 3'h0;
    localparam logic [2:0]  DEC_MAX     = 3'h5;
    localparam logic [1:0]  SEL_A_B     = 2'h0;
    localparam logic [1:0]  SEL_A       = 2'h1;
    localparam logic [1:0]  SEL_B       = 2'h2;
    localparam logic [1:0]  SEL_AVG     = 2'h3;
    localparam logic [15:0] LFSR_SEED   = 16'hace1;
    localparam logic [15:0] LFSR_TAPS   = 16'hb400;
    localparam logic [4:0]  PAT_LAST    = 5'h13;

    typedef struct packed {
        logic [1:0]       data_skew;
        logic [1:0]       clk_skew;
        logic [PAT_W-1:0] pattern;
        logic             scramble;
        logic             avg;
        logic [1:0]       sel;
        logic             dig;
        logic             ddc;
        logic             mux_en;
        logic [2:0]       dec;
        logic             real_out;
        logic             inv;
    } adcdp_cfg_type;

    typedef enum {PH_0, PH_90, PH_180, PH_270} adcdp_phase_type;
endpackage

// [core/adcdp_dec_if.sv]
// bundle between the sample path and one decimating lane
// assumes both ends run on the sample clock
`timescale 1ns/10ps
interface adcdp_dec_if #(parameter int W = 16);
    logic         in_valid;
    logic [W-1:0] in_data;
    logic [2:0]   code;
    logic         out_valid;
    logic [W-1:0] out_data;
    modport core (input in_valid, in_data, code,
                  output out_valid, out_data);
    modport feed (output in_valid, in_data, code,
                  input out_valid, out_data);
endinterface

// [core/adcdp_decim.sv]
// one decimating lane: boxcar average over 2**code samples
// assumes in_data is signed and code never exceeds MAXLOG
`timescale 1ns/10ps
module adcdp_decim
    import adcdp_pkg::*;
#(
    parameter int W      = 16,
    parameter int MAXLOG = 5
) (
    // clock and reset
    input wire logic     clk,
    input wire logic     rst_n,
    // lane
    adcdp_dec_if.core    d
);
    localparam int AW = W + MAXLOG;

    logic [AW-1:0]     acc_q;
    logic [MAXLOG-1:0] cnt_q;
    logic              valid_q;
    logic [W-1:0]      data_q;
    logic [AW-1:0]     sum;
    logic [MAXLOG-1:0] last;
    logic [AW-1:0]     shifted;

    assign sum     = acc_q + {{MAXLOG{d.in_data[W-1]}}, d.in_data};
    assign last    = MAXLOG'((1 << d.code) - 1);
    assign shifted = AW'($signed(sum) >>> d.code);

    // >= keeps the lane alive if the ratio shrinks mid-block
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q   <= '0;
            cnt_q   <= '0;
            valid_q <= 1'b0;
            data_q  <= '0;
        end else begin
            valid_q <= 1'b0;
            if (d.in_valid) begin
                if (d.code == DEC_BYPASS) begin
                    data_q  <= d.in_data;
                    valid_q <= 1'b1;
                    acc_q   <= '0;
                    cnt_q   <= '0;
                end else if (cnt_q >= last) begin
                    data_q  <= shifted[W-1:0]; // R16
                    valid_q <= 1'b1;
                    acc_q   <= '0;
                    cnt_q   <= '0;
                end else begin
                    acc_q <= sum;
                    cnt_q <= cnt_q + 1'b1;
                end
            end
        end
    end

    assign d.out_valid = valid_q;
    assign d.out_data  = data_q;
endmodule

// [core/adcdp_top.sv]
// apb configuration bank and sample-clock output path of the adc
// assumes sample_a/sample_b arrive every sample_clk edge, in that domain
//
// Function
// R01: data_lane_skew code 00 none, 01 early 50 ps, 10 late 50, 11 late 100.
// R02: bit_clock_skew uses the same four codes for the serial bit clock.
// R03: a 20-bit frame_clock_pattern, reset 0xffc00, shapes the frame clock.
// R04: with decimation bypassed the frame clock uses a fixed own pattern.
// R05: software sets 0xff000/0xff800/0xffc00 for real single-lane output.
// R06: software sets 0xfffff for complex single and half lane output.
// R07: scrambler_enable scrambles data only with digital_path_enable set.
// R08: channel averaging gives (A+B)/2 only with select 11 and all enables.
// R09: select 00 A/B, 01 A to both, 10 B to both, 11 average to both.
// R10: digital_path_enable low bypasses decimation and scrambling.
// R11: downconverter_enable switches decimation on for both channels.
// R12: the input select acts only while input_select_enable is set.
// R13: decimation code 000 bypass, 001..101 ratio 2..32, others unused.
// R14: real output gives low-pass decimation with no complex mixing.
// R15: the phase invert bit inverts the oscillator phase.
// R16: decimating by N yields one output per channel per N inputs.
`timescale 1ns/10ps
module adcdp_top
    import adcdp_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int W      = 16
) (
    // apb slave
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // sample side
    input  wire logic              sample_clk,
    input  wire logic [W-1:0]      sample_a,
    input  wire logic [W-1:0]      sample_b,
    // output path, lanes a_i a_q b_i b_q
    output logic                   lane_valid,
    output logic [3:0][W-1:0]      lane_data,
    output logic                   frame_clock,
    output logic [1:0]             data_lane_skew,
    output logic [1:0]             bit_clock_skew
);
    // ---------------- apb side ----------------
    logic [7:0]        lane_timing_skew_q;
    logic [23:0]       frame_pattern_scramble_q;
    logic [7:0]        digital_path_routing_q;
    logic [7:0]        decimation_control_q;
    logic              pready_q;
    logic              pslverr_q;
    logic [31:0]       prdata_q;
    logic [7:0]        idx;
    logic              hit;
    logic [31:0]       rd_d;
    logic              wr_go;
    logic              pending;
    adcdp_cfg_type     cfg_now;
    adcdp_cfg_type     shadow_q;
    logic              req_q;
    logic              ack_s1;
    logic              ack_s2;
    logic              ack_q;
    localparam adcdp_cfg_type CFG_RST =
        '{pattern: FRAME_RESET[PAT_W-1:0], default: '0};

    assign idx = paddr[ADDR_LSB +: 8];
    assign hit = (paddr[ADDR_LSB-1:0] == '0) &&
                 (paddr[ADDR_W-1:ADDR_LSB+8] == '0) &&
                 (idx == IDX_SKEW || idx == IDX_FRAME ||
                  idx == IDX_ROUTE || idx == IDX_DECIM ||
                  idx == IDX_STATUS);
    // one wait state: the answer comes in the second access cycle
    assign wr_go = psel && penable && pready_q && pwrite && !pslverr_q;

    always_comb begin
        rd_d = '0;
        case (idx)
            IDX_SKEW:   rd_d[3:0] = lane_timing_skew_q[3:0];
            IDX_FRAME:  rd_d[23:0] = frame_pattern_scramble_q;
            IDX_ROUTE:  rd_d[7:0] = digital_path_routing_q;
            IDX_DECIM:  rd_d[7:0] = decimation_control_q;
            IDX_STATUS: rd_d[STAT_PEND_BIT] = pending ||
                                              (cfg_now != shadow_q);
            default:    rd_d = '0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else begin
            pready_q  <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !hit;
            if (psel && penable && !pready_q) begin
                prdata_q <= (hit && !pwrite) ? rd_d : '0;
            end
        end
    end

    // reserved bits are not stored and read as zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lane_timing_skew_q       <= '0;
            frame_pattern_scramble_q <= FRAME_RESET; // R03
            digital_path_routing_q   <= '0;
            decimation_control_q     <= '0;
        end else if (wr_go) begin
            case (idx)
                IDX_SKEW:
                    lane_timing_skew_q <= {4'h0, pwdata[3:0]};
                IDX_FRAME:
                    frame_pattern_scramble_q <=
                        {1'b0, pwdata[FRAME_SCR_BIT], 2'h0,
                         pwdata[PAT_W-1:0]};
                IDX_ROUTE:
                    digital_path_routing_q <= {2'h0, pwdata[5:1], 1'b0};
                IDX_DECIM:
                    decimation_control_q <=
                        {pwdata[7:3], 2'h0, pwdata[DEC_INV_BIT]};
                default: ;
            endcase
        end
    end

    always_comb begin
        cfg_now.data_skew = lane_timing_skew_q[SKEW_DATA_LSB +: 2];
        cfg_now.clk_skew  = lane_timing_skew_q[SKEW_CLK_LSB +: 2];
        cfg_now.pattern   = frame_pattern_scramble_q[PAT_W-1:0];
        cfg_now.scramble  = frame_pattern_scramble_q[FRAME_SCR_BIT];
        cfg_now.avg       = digital_path_routing_q[ROUTE_AVG_BIT];
        cfg_now.sel       = digital_path_routing_q[ROUTE_SEL_LSB +: 2];
        cfg_now.dig       = digital_path_routing_q[ROUTE_DIG_BIT];
        cfg_now.ddc       = digital_path_routing_q[ROUTE_DDC_BIT];
        cfg_now.mux_en    = decimation_control_q[DEC_MUX_BIT];
        cfg_now.dec       = decimation_control_q[DEC_CODE_LSB +: 3];
        cfg_now.real_out  = decimation_control_q[DEC_REAL_BIT];
        cfg_now.inv       = decimation_control_q[DEC_INV_BIT];
    end

    // shadow stays frozen while a request is in flight, so the
    // sample side may capture all bits at once
    assign pending = (req_q != ack_s2);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shadow_q <= CFG_RST;
            req_q    <= 1'b0;
        end else if (!pending && cfg_now != shadow_q) begin
            shadow_q <= cfg_now;
            req_q    <= ~req_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
        end else begin
            ack_s1 <= ack_q;
            ack_s2 <= ack_s1;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ---------------- sample side ----------------
    logic               srst_s1;
    logic               srst_n;
    logic               req_s1;
    logic               req_s2;
    logic               req_s3;
    adcdp_cfg_type      cfg_q;
    logic signed [W:0]  sum_ab;
    logic [W-1:0]       avg_ab;
    logic               avg_ok;
    logic [1:0]         sel_eff;
    logic [W-1:0]       route0;
    logic [W-1:0]       route1;
    logic [W-1:0]       r0_q;
    logic [W-1:0]       r1_q;
    logic               rv_q;
    logic               mixing;
    logic               scr_on;
    logic [2:0]         code_eff;
    adcdp_phase_type    ph_q;
    logic [3:0][W-1:0]  mix_d;
    logic [3:0]         dec_v;
    logic [3:0][W-1:0]  dec_d;
    logic [15:0]        lfsr_q;
    logic               lane_valid_q;
    logic [3:0][W-1:0]  lane_data_q;
    logic [4:0]         pat_idx_q;
    logic [PAT_W-1:0]   pat_eff;
    logic               frame_q;
    logic [1:0]         dskew_q;
    logic [1:0]         cskew_q;

    // reset leaves the sample domain on a sample_clk edge
    always_ff @(posedge sample_clk or negedge presetn) begin
        if (!presetn) begin
            srst_s1 <= 1'b0;
            srst_n  <= 1'b0;
        end else begin
            srst_s1 <= 1'b1;
            srst_n  <= srst_s1;
        end
    end

    always_ff @(posedge sample_clk or negedge srst_n) begin
        if (!srst_n) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_s3 <= 1'b0;
            ack_q  <= 1'b0;
            cfg_q  <= CFG_RST;
        end else begin
            req_s1 <= req_q;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
            if (req_s2 != req_s3) begin
                cfg_q <= shadow_q;
                ack_q <= req_s2;
            end
        end
    end

    assign sum_ab  = $signed({sample_a[W-1], sample_a}) +
                     $signed({sample_b[W-1], sample_b});
    assign avg_ab  = sum_ab[W:1];
    assign avg_ok  = cfg_q.avg && cfg_q.mux_en && cfg_q.sel == SEL_AVG &&
                     cfg_q.ddc && cfg_q.dig; // R08
    assign sel_eff = cfg_q.mux_en ? cfg_q.sel : SEL_A_B; // R12

    // select 11 without full averaging falls back to straight routing
    always_comb begin
        route0 = sample_a;
        route1 = sample_b;
        case (sel_eff) // R09
            SEL_A: begin
                route0 = sample_a;
                route1 = sample_a;
            end
            SEL_B: begin
                route0 = sample_b;
                route1 = sample_b;
            end
            SEL_AVG: begin
                route0 = avg_ok ? avg_ab : sample_a;
                route1 = avg_ok ? avg_ab : sample_b;
            end
            default: ;
        endcase
    end

    always_ff @(posedge sample_clk or negedge srst_n) begin
        if (!srst_n) begin
            r0_q <= '0;
            r1_q <= '0;
            rv_q <= 1'b0;
        end else begin
            r0_q <= cfg_q.dig ? route0 : sample_a; // R10
            r1_q <= cfg_q.dig ? route1 : sample_b; // R10
            rv_q <= 1'b1;
        end
    end

    assign mixing   = cfg_q.dig && cfg_q.ddc && !cfg_q.real_out; // R14
    assign scr_on   = cfg_q.scramble && cfg_q.dig; // R07
    assign code_eff = (cfg_q.dig && cfg_q.ddc && cfg_q.dec <= DEC_MAX) ?
                      cfg_q.dec : DEC_BYPASS; // R11 R13

    // quarter-rate oscillator: i and q take +x, 0, -x, 0 in turn
    always_ff @(posedge sample_clk or negedge srst_n) begin
        if (!srst_n) begin
            ph_q <= PH_0;
        end else if (!mixing) begin
            ph_q <= PH_0;
        end else if (rv_q) begin
            case (ph_q)
                PH_0:    ph_q <= PH_90;
                PH_90:   ph_q <= PH_180;
                PH_180:  ph_q <= PH_270;
                PH_270:  ph_q <= PH_0;
                default: ph_q <= PH_0;
            endcase
        end
    end

    // full-scale negative wraps on negation; inputs rarely reach it
    always_comb begin
        mix_d[0] = r0_q;
        mix_d[1] = '0;
        mix_d[2] = r1_q;
        mix_d[3] = '0;
        if (mixing) begin
            case (ph_q)
                PH_90: begin
                    mix_d[0] = '0;
                    mix_d[2] = '0;
                    mix_d[1] = cfg_q.inv ? r0_q : -r0_q; // R15
                    mix_d[3] = cfg_q.inv ? r1_q : -r1_q; // R15
                end
                PH_180: begin
                    mix_d[0] = -r0_q;
                    mix_d[2] = -r1_q;
                end
                PH_270: begin
                    mix_d[0] = '0;
                    mix_d[2] = '0;
                    mix_d[1] = cfg_q.inv ? -r0_q : r0_q; // R15
                    mix_d[3] = cfg_q.inv ? -r1_q : r1_q; // R15
                end
                default: ;
            endcase
        end
    end

    for (genvar g = 0; g < 4; g++) begin : g_lane
        adcdp_dec_if #(.W(W)) dif ();
        assign dif.in_valid = rv_q;
        assign dif.in_data  = mix_d[g];
        assign dif.code     = code_eff;
        assign dec_v[g]     = dif.out_valid;
        assign dec_d[g]     = dif.out_data;
        adcdp_decim #(.W(W)) u_decim (
            .clk   (sample_clk),
            .rst_n (srst_n),
            .d     (dif.core)
        );
    end

    // scrambler word steps once per output sample
    always_ff @(posedge sample_clk or negedge srst_n) begin
        if (!srst_n) begin
            lfsr_q       <= LFSR_SEED;
            lane_valid_q <= 1'b0;
            lane_data_q  <= '0;
        end else begin
            lane_valid_q <= dec_v[0];
            if (dec_v[0]) begin
                for (int i = 0; i < 4; i++) begin
                    lane_data_q[i] <= scr_on ?
                        dec_d[i] ^ lfsr_q[W-1:0] : dec_d[i]; // R07
                end
                if (scr_on) begin
                    lfsr_q <= {lfsr_q[14:0], ^(lfsr_q & LFSR_TAPS)};
                end
            end
        end
    end

    assign pat_eff = (code_eff == DEC_BYPASS) ?
                     PAT_BYPASS : cfg_q.pattern; // R04

    always_ff @(posedge sample_clk or negedge srst_n) begin
        if (!srst_n) begin
            pat_idx_q <= '0;
            frame_q   <= 1'b0;
        end else begin
            pat_idx_q <= (pat_idx_q == PAT_LAST) ? '0 : pat_idx_q + 1'b1;
            frame_q   <= pat_eff[PAT_LAST - pat_idx_q]; // R03
        end
    end

    always_ff @(posedge sample_clk or negedge srst_n) begin
        if (!srst_n) begin
            dskew_q <= '0;
            cskew_q <= '0;
        end else begin
            dskew_q <= cfg_q.data_skew; // R01
            cskew_q <= cfg_q.clk_skew; // R02
        end
    end

    assign lane_valid     = lane_valid_q;
    assign lane_data      = lane_data_q;
    assign frame_clock    = frame_q;
    assign data_lane_skew = dskew_q;
    assign bit_clock_skew = cskew_q;
endmodule

// [tb/adcdp_top_asserts.sv]
// apb-side checks of the digital path configuration bank
// assumes it is bound onto adcdp_top
`timescale 1ns/10ps
module adcdp_top_asserts
    import adcdp_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // apb
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr
);
    localparam logic [ADDR_W-1:0] AS = ADDR_W'(IDX_SKEW) << ADDR_LSB;
    localparam logic [ADDR_W-1:0] AF = ADDR_W'(IDX_FRAME) << ADDR_LSB;
    localparam logic [ADDR_W-1:0] AR = ADDR_W'(IDX_ROUTE) << ADDR_LSB;
    localparam logic [ADDR_W-1:0] AD = ADDR_W'(IDX_DECIM) << ADDR_LSB;
    logic rd;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    assign rd = pready && !pwrite;
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    wait_state_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready not in second access cycle");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    err_zero_a: assert property (pslverr |-> pready && prdata == 0)
        else $error("error without pready or with data");
    misalign_err_a: assert property (pready && paddr[1:0] != 0 |-> pslverr)
        else $error("misaligned access accepted");
    skew_fields_a: assert property (
        rd && paddr == AS |-> prdata[31:4] == 0 && !pslverr)
        else $error("skew read wrong");
    frame_fields_a: assert property (
        rd && paddr == AF |-> prdata[31:23] == 0 && prdata[21:20] == 0)
        else $error("frame read reserved bits set");
    route_fields_a: assert property (
        rd && paddr == AR |-> prdata[31:6] == 0 && !prdata[0])
        else $error("route read reserved bits set");
    decim_fields_a: assert property (
        rd && paddr == AD |-> prdata[31:8] == 0 && prdata[2:1] == 0)
        else $error("decimation read reserved bits set");
endmodule

// [tb/adcdp_sink.sv]
// receiving logic at the serial output: counts samples, frame ones
// assumes it runs on the sample clock of the device
`timescale 1ns/10ps
module adcdp_sink #(
    parameter int W = 16
) (
    // link side
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              lane_valid,
    input wire logic [3:0][W-1:0] lane_data,
    input wire logic              frame_clock,
    // observations
    output int                    n_valid,
    output logic [3:0][W-1:0]     last,
    output int                    fc_ones
);
    logic [19:0] fc_q;
    // ones in the last period are phase-free, unlike the raw pattern
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fc_q <= '0;
            n_valid <= 0;
            last <= '0;
        end else begin
            fc_q <= {fc_q[18:0], frame_clock};
            if (lane_valid) begin
                n_valid <= n_valid + 1;
                last <= lane_data;
            end
        end
    end
    assign fc_ones = $countones(fc_q);
endmodule

// [tb/adcdp_tb.sv]
// self-checking bench of the digital path configuration bank
// assumes adcdp_top, adcdp_sink and the apb checker alongside
`timescale 1ns/10ps
module testbench import adcdp_pkg::*;;
    localparam logic [11:0] A_SK = 12'(IDX_SKEW) << ADDR_LSB;
    localparam logic [11:0] A_FR = 12'(IDX_FRAME) << ADDR_LSB;
    localparam logic [11:0] A_RT = 12'(IDX_ROUTE) << ADDR_LSB;
    localparam logic [11:0] A_DC = 12'(IDX_DECIM) << ADDR_LSB;
    localparam logic [11:0] A_ST = 12'(IDX_STATUS) << ADDR_LSB;
    logic            pclk, sample_clk, lane_valid, frame_clock, pready;
    logic            presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0]     paddr = 0;
    logic [31:0]     pwdata = 0, prdata, rd, v;
    logic            pslverr, er;
    logic [15:0]     sample_a = 0, sample_b = 0, ca = 0, cb = 0, s, av;
    logic [3:0][15:0] lane_data, last;
    logic [1:0]      dsk, csk;
    logic [31:0]     seed = 32'h00002a84;
    int              n_valid, fc_ones, num_errors, total_checks, cyc;
    logic [11:0]     ra [4] = '{A_SK, A_FR, A_RT, A_DC};
    logic [31:0]     rm [4] = '{32'hf, 32'h4fffff, 32'h3e, 32'hf9};
    logic [31:0]     mdl [4] = '{0, 32'h000ffc00, 0, 0};

    adcdp_top #(.ADDR_W(12), .W(16)) u_dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_clk(sample_clk), .sample_a(sample_a),
        .sample_b(sample_b), .lane_valid(lane_valid),
        .lane_data(lane_data), .frame_clock(frame_clock),
        .data_lane_skew(dsk), .bit_clock_skew(csk));
    adcdp_sink #(.W(16)) u_sink (
        .clk(sample_clk), .rst_n(presetn), .lane_valid(lane_valid),
        .lane_data(lane_data), .frame_clock(frame_clock),
        .n_valid(n_valid), .last(last), .fc_ones(fc_ones));

    initial begin
        pclk = 0;
        forever #10 pclk = ~pclk;
    end
    // offset keeps the link clock out of phase with pclk
    initial begin
        sample_clk = 0;
        #7;
        forever #15 sample_clk = ~sample_clk;
    end
    always @(posedge sample_clk) begin
        sample_a <= ca;
        sample_b <= cb;
    end
    always @(posedge pclk) begin
        cyc = cyc + 1;
        if (cyc == 40000) begin
            num_errors++;
            finish_test();
        end
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [63:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 0);
        chk(64'(rd), 64'(e));
        chk(64'(er), 0);
    endtask
    // the crossing is done once status clears; lanes then need flushing
    task automatic settle(input int n);
        apb(0, A_ST, 0);
        while (rd[0] !== 1'b0) apb(0, A_ST, 0);
        repeat (n) @(posedge sample_clk);
    endtask
    task automatic path(input logic [31:0] rt, dc, input int k, ones,
                        input logic [15:0] e0, e2, input logic lc);
        int n0;
        apb(1, A_RT, rt);
        apb(1, A_DC, dc);
        settle(80);
        n0 = n_valid;
        repeat (64) @(posedge sample_clk);
        chk(64'(n_valid - n0), 64'(64 >> k));
        chk(64'(fc_ones), 64'(ones));
        if (lc)
            chk(last, {16'h0, e2, 16'h0, e0});
    endtask
    task automatic finish_test();
        if (num_errors == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge sample_clk);
        @(posedge pclk);
        presetn <= 1;
        for (int i = 0; i < 4; i++) rdc(ra[i], mdl[i]);
        rdc(A_ST, 0);
        apb(0, 12'h07c, 32'h1);
        chk(64'({er, rd}), 64'h100000000);
        for (int i = 0; i < 4; i++) begin
            v = xs();
            mdl[i] = v & rm[i];
            apb(1, ra[i], v);
            rdc(ra[i], mdl[i]);
        end
        for (int c = 0; c < 4; c++) begin
            apb(1, A_SK, 32'(c * 4 + 3 - c));
            settle(8);
            chk(64'({dsk, csk}), 64'(c * 4 + 3 - c));
        end
        v = xs();
        ca = {v[15], v[15], v[13:1], 1'b0};
        cb = {v[31], v[31], v[29:17], 1'b0};
        s = ca + cb;
        av = {s[15], s[15:1]};
        apb(1, A_FR, 32'h004ff800);
        path(32'h00, 32'h00, 0, 8, ca, cb, 1);
        path(32'h0a, 32'hd8, 0, 8, ca, cb, 1);
        path(32'h06, 32'h18, 1, 9, ca, cb, 0);
        chk(64'(last[0] !== ca), 1);
        apb(1, A_FR, 32'h000ff800);
        for (int i = 0; i < 4; i++)
            path(32'h26 | (i << 3), 32'h98, 1, 9,
                 (i == 2) ? cb : (i == 3) ? av : ca,
                 (i == 1) ? ca : (i == 3) ? av : cb, 1);
        path(32'h16, 32'h18, 1, 9, ca, cb, 1);
        path(32'h1e, 32'h98, 1, 9, ca, cb, 1);
        for (int c = 0; c < 8; c++)
            path(32'h06, 32'h08 | (c << 4), (c > 5) ? 0 : c,
                 (c == 0 || c > 5) ? 8 : 9, ca, cb, 1);
        path(32'h04, 32'h58, 0, 8, ca, cb, 1);
        apb(1, A_FR, 32'h000fffff);
        path(32'h06, 32'h20, 2, 20, 16'h0, 16'h0, 1);
        path(32'h06, 32'h21, 2, 20, 16'h0, 16'h0, 1);
        finish_test();
    end
endmodule

bind adcdp_top adcdp_top_asserts #(.ADDR_W(ADDR_W)) u_chk (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
